// ===== shared/pll_regs_pkg.sv
// constants, types and lookup data for the clock synthesizer divider and spread registers
// assumes one 200 MHz clock and a byte-wide register port driven by the serial bus engine
//
// Operation
// - index 9 returns fixed identity byte
// - index 10 bit 7 enables divider programming
// - feedback bits 7:0 index 12, bit 8 index 11
// - index 11: feedback bit 9, input divider
// - vco equals 25 times (n+8)/(m+2)
// - power-up reference divider registers come from strap and table, storage dividers from fixed defaults
// - 15-bit spread amount in indices 13, 14
// - storage pll dividers at indices 15, 16
// - strap and table select bits 2:0 pick table defaults
package pll_regs_pkg;

    // ---------------------------------------------------------------
    // register indices
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_DEVICE_IDENTITY        = 8'h09;
    localparam logic [7:0] IDX_DIVIDER_PROGRAM_CONTROL = 8'h0A;
    localparam logic [7:0] IDX_REF_PLL_DIVIDER_HIGH   = 8'h0B;
    localparam logic [7:0] IDX_REF_PLL_FEEDBACK_LOW   = 8'h0C;
    localparam logic [7:0] IDX_REF_SPREAD_AMOUNT_LOW  = 8'h0D;
    localparam logic [7:0] IDX_REF_SPREAD_AMOUNT_HIGH = 8'h0E;
    localparam logic [7:0] IDX_STORAGE_PLL_DIVIDER_HIGH = 8'h0F;
    localparam logic [7:0] IDX_STORAGE_PLL_FEEDBACK_LOW = 8'h10;

    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam int         POS_PROGRAM_ENABLE  = 7;  // in the control byte
    localparam int         POS_FEEDBACK_BIT8   = 7;  // in the divider high byte
    localparam int         POS_FEEDBACK_BIT9   = 6;
    localparam logic [7:0] IDENTITY_CODE       = 8'hA5;  // arbitrary value
    localparam logic [7:0] RESET_BYTE          = 8'h00;
    localparam logic [7:0] UNMAPPED_READ       = 8'h00;

    // vco = VCO_REF_MHZ * (n + N_OFFSET) / (m + M_OFFSET), kept for reference models
    localparam int         VCO_REF_MHZ         = 25;
    localparam int         N_OFFSET            = 8;
    localparam int         M_OFFSET            = 2;

    // ---------------------------------------------------------------
    // power-up sequencing
    // ---------------------------------------------------------------
    localparam logic [1:0] SETTLE_CYCLES       = 2'h2;  // strap synchroniser depth
    localparam logic [5:0] STORAGE_M_FIXED     = 6'h01;  // fixed input divider, late revision
    localparam logic [9:0] STORAGE_N_DEFAULT   = 10'h004;
    localparam logic [14:0] SPREAD_DEFAULT     = 15'h0000;

    // table entries: input divider 48 (divide by 50), so vco = (n + 8) / 2 MHz
    localparam logic [5:0] TABLE_M             = 6'h30;
    localparam logic [9:0] TABLE_N [16] = '{
        10'h0AC, 10'h0AF, 10'h0B1, 10'h0B4, 10'h0B6, 10'h0B8, 10'h0BB, 10'h0BE,
        10'h0C0, 10'h0C3, 10'h0C5, 10'h0C8, 10'h0CA, 10'h0CD, 10'h0CF, 10'h0D4
    };

    typedef enum logic [2:0] {
        ST_SETTLE = 3'b001,
        ST_LOAD   = 3'b010,
        ST_RUN    = 3'b100
    } boot_state_t;

    // table feedback divider for a four-bit frequency selection
    function automatic logic [9:0] table_feedback(input logic [3:0] sel);
        return TABLE_N[sel];
    endfunction

endpackage

// ===== logic/pll_divider_spread_regs.sv
// divider and spread register bytes 9 to 16 of the clock synthesizer
// assumes the serial bus engine presents one byte access at a time on clk
`timescale 1ns/100ps
`default_nettype none
module pll_divider_spread_regs
    import pll_regs_pkg::*;
#(
    parameter bit LATE_REVISION = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_index,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [3:0] table_select,
    input  wire logic       freq_select_bit,
    output logic [7:0]      reg_rdata,
    output logic            reg_rvalid,
    output logic [9:0]      ref_feedback_divider,
    output logic [5:0]      ref_input_divider,
    output logic [14:0]     ref_spread_amount,
    output logic [9:0]      storage_feedback_divider,
    output logic [5:0]      storage_input_divider,
    output logic            boot_done
);

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic              strap_meta;
    logic              strap_sync;
    logic [1:0]        settle_count;
    boot_state_t       state;
    logic              program_enable;
    logic [9:0]        ref_n;
    logic [5:0]        ref_m;
    logic [14:0]       spread;
    logic [9:0]        sto_n;
    logic [5:0]        sto_m;
    logic [7:0]        next_rdata;
    logic              write_ok;
    logic [3:0]        boot_select;

    assign write_ok    = reg_write && (state == ST_RUN);
    assign boot_select = {strap_sync, table_select[2:0]};

    // ---------------------------------------------------------------
    // strap synchroniser
    // ---------------------------------------------------------------

    // strap pin through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
        end else begin
            strap_meta <= freq_select_bit;
            strap_sync <= strap_meta;
        end
    end

    // ---------------------------------------------------------------
    // power-up sequence
    // ---------------------------------------------------------------

    // wait for the strap to settle, load defaults once, then run
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= ST_SETTLE;
            settle_count <= 2'h0;
        end else begin
            unique case (state)
                ST_SETTLE: begin
                    settle_count <= settle_count + 2'h1;
                    if (settle_count == SETTLE_CYCLES - 2'h1) begin
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    state <= ST_RUN;
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_SETTLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // writable registers
    // ---------------------------------------------------------------

    // programming enable, reserved bits dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_enable <= 1'b0;
        end else if (write_ok && reg_index == IDX_DIVIDER_PROGRAM_CONTROL) begin
            program_enable <= reg_wdata[POS_PROGRAM_ENABLE];
        end
    end

    // reference pll dividers: strap and table at boot, bus writes after
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_n <= '0;
            ref_m <= '0;
        end else if (state == ST_LOAD) begin
            ref_n <= table_feedback(boot_select);
            ref_m <= TABLE_M;
        end else if (write_ok && reg_index == IDX_REF_PLL_DIVIDER_HIGH) begin
            ref_n[8] <= reg_wdata[POS_FEEDBACK_BIT8];
            ref_n[9] <= reg_wdata[POS_FEEDBACK_BIT9];
            ref_m    <= reg_wdata[5:0];
        end else if (write_ok && reg_index == IDX_REF_PLL_FEEDBACK_LOW) begin
            ref_n[7:0] <= reg_wdata;
        end
    end

    // spread amount, top bit of the high byte reserved
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spread <= '0;
        end else if (state == ST_LOAD) begin
            spread <= SPREAD_DEFAULT;
        end else if (write_ok && reg_index == IDX_REF_SPREAD_AMOUNT_LOW) begin
            spread[7:0] <= reg_wdata;
        end else if (write_ok && reg_index == IDX_REF_SPREAD_AMOUNT_HIGH) begin
            spread[14:8] <= reg_wdata[6:0];
        end
    end

    // storage pll dividers, same layout as the reference pair
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sto_n <= '0;
            sto_m <= '0;
        end else if (state == ST_LOAD) begin
            sto_n <= STORAGE_N_DEFAULT;
            sto_m <= STORAGE_M_FIXED;
        end else if (write_ok && reg_index == IDX_STORAGE_PLL_DIVIDER_HIGH) begin
            sto_n[8] <= reg_wdata[POS_FEEDBACK_BIT8];
            sto_n[9] <= reg_wdata[POS_FEEDBACK_BIT9];
            sto_m    <= LATE_REVISION ? STORAGE_M_FIXED : reg_wdata[5:0];
        end else if (write_ok && reg_index == IDX_STORAGE_PLL_FEEDBACK_LOW) begin
            sto_n[7:0] <= reg_wdata;
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------

    // byte selection for reads, unmapped indices read zero
    always_comb begin
        unique case (reg_index)
            IDX_DEVICE_IDENTITY:          next_rdata = IDENTITY_CODE;
            IDX_DIVIDER_PROGRAM_CONTROL:  next_rdata = {program_enable, 7'h00};
            IDX_REF_PLL_DIVIDER_HIGH:     next_rdata = {ref_n[8], ref_n[9], ref_m};
            IDX_REF_PLL_FEEDBACK_LOW:     next_rdata = ref_n[7:0];
            IDX_REF_SPREAD_AMOUNT_LOW:    next_rdata = spread[7:0];
            IDX_REF_SPREAD_AMOUNT_HIGH:   next_rdata = {1'b0, spread[14:8]};
            IDX_STORAGE_PLL_DIVIDER_HIGH: next_rdata = {sto_n[8], sto_n[9], sto_m};
            IDX_STORAGE_PLL_FEEDBACK_LOW: next_rdata = sto_n[7:0];
            default:                      next_rdata = UNMAPPED_READ;
        endcase
    end

    // read answer one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= RESET_BYTE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // dividers in effect
    // ---------------------------------------------------------------

    // programmed values only while enabled, else the live table entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_feedback_divider <= '0;
            ref_input_divider    <= '0;
        end else if (program_enable) begin
            ref_feedback_divider <= ref_n;
            ref_input_divider    <= ref_m;
        end else begin
            ref_feedback_divider <= table_feedback(table_select);
            ref_input_divider    <= TABLE_M;
        end
    end

    // storage pair follows its registers one cycle later, no enable gates it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            storage_feedback_divider <= '0;
            storage_input_divider    <= '0;
        end else begin
            storage_feedback_divider <= sto_n;
            storage_input_divider    <= sto_m;
        end
    end

    // spread amount in effect, one cycle behind the stored bytes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_spread_amount <= '0;
        end else begin
            ref_spread_amount <= spread;
        end
    end

    // boot status: high once defaults are loaded and writes are taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_done <= 1'b0;
        end else begin
            boot_done <= (state == ST_RUN);
        end
    end

endmodule
`default_nettype wire

// ===== bench/host_model.sv
// host side of the register port: one byte read or write at a time
// tasks are called by the testbench just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output logic [7:0]      reg_index,
    output logic [7:0]      reg_wdata,
    output logic            reg_write,
    output logic            reg_read
);
    // idle port at time zero
    initial begin
        reg_index = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read  = 1'b0;
    end
    // write strobe held up to exactly one taking edge
    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        @(posedge clk);
        reg_index <= idx;
        reg_wdata <= data;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    // read strobe; answer taken once the taking edge has settled
    task automatic rd(input logic [7:0] idx, output logic [7:0] data, output logic valid);
        @(posedge clk);
        reg_index <= idx;
        reg_read  <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        data  = reg_rdata;
        valid = reg_rvalid;
    endtask
endmodule
`default_nettype wire

// ===== bench/pll_regs_assertions.sv
// port checker for the divider and spread register block
// bound to every instance of pll_divider_spread_regs
`timescale 1ns/100ps
`default_nettype none
module pll_regs_assertions
    import pll_regs_pkg::*;
#(
    parameter bit LATE_REVISION = 1'b1
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_index,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic [9:0]  ref_feedback_divider,
    input wire logic [5:0]  ref_input_divider,
    input wire logic [14:0] ref_spread_amount,
    input wire logic [9:0]  storage_feedback_divider,
    input wire logic [5:0]  storage_input_divider,
    input wire logic        boot_done
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic en_sh;
    // shadow of the programming enable bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            en_sh <= 1'b0;
        else if (boot_done && reg_write && !reg_read && reg_index == IDX_DIVIDER_PROGRAM_CONTROL)
            en_sh <= reg_wdata[POS_PROGRAM_ENABLE];
    end
    // single read and accepted write
    sequence s_rd(logic [7:0] idx);
        reg_read && !reg_write && reg_index == idx;
    endsequence
    sequence s_wr(logic [7:0] idx);
        boot_done && reg_write && !reg_read && reg_index == idx;
    endsequence
    a_read_answers: assert property (reg_read |=> reg_rvalid)
        else $error("read not answered next cycle");
    a_identity_fixed: assert property (s_rd(IDX_DEVICE_IDENTITY) |=> reg_rdata == IDENTITY_CODE)
        else $error("identity byte wrong");
    a_ctrl_reserved_zero: assert property (s_rd(IDX_DIVIDER_PROGRAM_CONTROL) |=> reg_rdata[6:0] == 7'h00)
        else $error("control reserved bits not zero");
    a_spread_reserved_zero: assert property (s_rd(IDX_REF_SPREAD_AMOUNT_HIGH) |=> !reg_rdata[7])
        else $error("spread reserved bit not zero");
    a_feedback_applies: assert property (s_wr(IDX_REF_PLL_FEEDBACK_LOW) ##0 en_sh |-> ##2
        ref_feedback_divider[7:0] == $past(reg_wdata, 2))
        else $error("written feedback byte not in effect");
    a_spread_follows: assert property (s_wr(IDX_REF_SPREAD_AMOUNT_LOW) |-> ##2
        ref_spread_amount[7:0] == $past(reg_wdata, 2))
        else $error("spread low byte not in effect");
    a_storage_follows: assert property (s_wr(IDX_STORAGE_PLL_FEEDBACK_LOW) |-> ##2
        storage_feedback_divider[7:0] == $past(reg_wdata, 2))
        else $error("storage feedback byte not in effect");
    a_storage_m_fixed: assert property (boot_done && LATE_REVISION |-> storage_input_divider == STORAGE_M_FIXED)
        else $error("storage input divider not fixed");
    a_table_in_effect: assert property ((boot_done && !en_sh) [*2] |-> ref_input_divider == TABLE_M)
        else $error("table input divider not in effect");
endmodule
bind pll_divider_spread_regs pll_regs_assertions #(.LATE_REVISION(LATE_REVISION)) i_pll_regs_assertions (
    .clk, .rst_n, .reg_index, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid,
    .ref_feedback_divider, .ref_input_divider, .ref_spread_amount, .storage_feedback_divider,
    .storage_input_divider, .boot_done);
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the divider and spread register bytes
// drives strap and table inputs itself, register traffic through the host model
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import pll_regs_pkg::*;
    logic        clk, rst_n, freq_select_bit, reg_write, reg_read, reg_rvalid, boot_done;
    logic [3:0]  table_select;
    logic [7:0]  reg_index, reg_wdata, reg_rdata;
    logic [9:0]  ref_feedback_divider, storage_feedback_divider;
    logic [5:0]  ref_input_divider, storage_input_divider;
    logic [14:0] ref_spread_amount;
    int          miscompares = 0, comparisons = 0;
    pll_divider_spread_regs i_pll_divider_spread_regs (.clk, .rst_n, .reg_index, .reg_wdata,
        .reg_write, .reg_read, .table_select, .freq_select_bit, .reg_rdata, .reg_rvalid,
        .ref_feedback_divider, .ref_input_divider, .ref_spread_amount,
        .storage_feedback_divider, .storage_input_divider, .boot_done);
    host_model i_host_model (.clk, .reg_rdata, .reg_rvalid, .reg_index, .reg_wdata, .reg_write,
        .reg_read);
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] data;
        logic       valid;
        i_host_model.rd(idx, data, valid);
        chk("read valid", 16'h0001, {15'h0000, valid});
        chk("read byte", {8'h00, exp}, {8'h00, data});
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // reset, a write refused while booting, then the power-up defaults
    task automatic t_boot(input logic strap, input logic [3:0] sel);
        int         n;
        logic [9:0] def_n;
        def_n = TABLE_N[{strap, sel[2:0]}];
        @(posedge clk);
        rst_n           <= 1'b0;
        freq_select_bit <= strap;
        table_select    <= sel;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        i_host_model.wr(IDX_DIVIDER_PROGRAM_CONTROL, 8'h80);
        n = 0;
        while (boot_done !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        settle();
        chk("boot done", 16'h0001, {15'h0000, boot_done});
        chk("boot feedback", {6'h00, TABLE_N[sel]}, {6'h00, ref_feedback_divider});
        chk("boot input", {10'h000, TABLE_M}, {10'h000, ref_input_divider});
        chk("boot storage n", {6'h00, STORAGE_N_DEFAULT}, {6'h00, storage_feedback_divider});
        chk("boot spread", {1'b0, SPREAD_DEFAULT}, {1'b0, ref_spread_amount});
        rdchk(IDX_REF_PLL_FEEDBACK_LOW, def_n[7:0]);
        rdchk(IDX_REF_PLL_DIVIDER_HIGH, {def_n[8], def_n[9], TABLE_M});
        rdchk(IDX_REF_SPREAD_AMOUNT_LOW, SPREAD_DEFAULT[7:0]);
        rdchk(IDX_DIVIDER_PROGRAM_CONTROL, RESET_BYTE);
        $display("boot test done");
    endtask
    // write then read back every byte, read-only and unmapped places too
    task automatic t_registers;
        logic [23:0] cases [9] = '{24'h095AA5, 24'h0AFF80, 24'h0EFF7F, 24'h0DC3C3, 24'h0BFFFF,
                                   24'h0C1212, 24'h0FFFC1, 24'h103434, 24'h207700};
        foreach (cases[i]) begin
            i_host_model.wr(cases[i][23:16], cases[i][15:8]);
            rdchk(cases[i][23:16], cases[i][7:0]);
        end
        settle();
        chk("feedback", 16'h0312, {6'h00, ref_feedback_divider});
        chk("input", 16'h003F, {10'h000, ref_input_divider});
        chk("vco", 16'(VCO_REF_MHZ * (786 + N_OFFSET) / (63 + M_OFFSET)),
            16'(VCO_REF_MHZ * (ref_feedback_divider + N_OFFSET) / (ref_input_divider + M_OFFSET)));
        chk("spread", 16'h7FC3, {1'b0, ref_spread_amount});
        chk("storage n", 16'h0334, {6'h00, storage_feedback_divider});
        chk("storage m", {10'h000, STORAGE_M_FIXED}, {10'h000, storage_input_divider});
        $display("register test done");
    endtask
    // enable off hands the dividers back to the table, on restores the stored ones
    task automatic t_disable;
        i_host_model.wr(IDX_DIVIDER_PROGRAM_CONTROL, 8'h00);
        table_select <= 4'h5;
        settle();
        chk("table feedback", {6'h00, TABLE_N[5]}, {6'h00, ref_feedback_divider});
        chk("table input", {10'h000, TABLE_M}, {10'h000, ref_input_divider});
        rdchk(IDX_REF_PLL_FEEDBACK_LOW, 8'h12);
        i_host_model.wr(IDX_DIVIDER_PROGRAM_CONTROL, 8'h80);
        settle();
        chk("restored feedback", 16'h0312, {6'h00, ref_feedback_divider});
        $display("enable test done");
    endtask
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence, second boot is a reset in mid-run
    initial begin
        rst_n = 1'b0;
        freq_select_bit = 1'b0;
        table_select = 4'h0;
        t_boot(1'b0, 4'hB);
        t_registers();
        t_disable();
        t_boot(1'b1, 4'h6);
        complete_run();
    end
    // watchdog well past the expected run length
    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire
